/* File: pkg/ddt_pkg.sv */
// Constants and types for the dual down-counter timer
//////////////////////////////////////////////////////////////////////////////
// Contract
// RL1 - Two identical down counters, each 32 or 16 bit, three modes.
// RL2 - Shared timer clock, per-counter count enable and prescaler of 1, 16 or 256.
// RL3 - Free-running mode wraps to maximum value at each zero.
// RL4 - Periodic mode reloads from load value at each zero.
// RL5 - One-shot mode loads on load write, counts to zero, then halts.
// RL6 - Load write while running restarts counter from the new value.
// RL7 - Background load keeps count; next periodic zero reloads new value.
// RL8 - Zero raises interrupt; only an interrupt clear write clears it.
// RL9 - Each interrupt output can be masked by a per-timer enable.
// RL10 - Live counter value is readable at any time.
// RL11 - All register accesses are decoded and timed by the bus clock.
// RL12 - System asserts reset asynchronously, releases synchronously, holds one period.
// RL13 - Reset: disabled, free-running, 16-bit, divide by 1, irq cleared but enabled; config is cfg_i ports, and periodic_select low gives periodic mode.
// RL14 - Reset: load value zero, counter value 0x0FFFFFFF.
// RL15 - Prescaler decrements only on edges where its count enable is high.
// RL16 - Counter decrements only when count enable high and prescaler pulses.
// RL17 - Timer clock edges synchronous with bus clock, not faster than it.
// RL18 - Read-only identification values uniquely identify the block.
// RL19 - 16-bit mode counts low 16 bits only; zero at low half 0x0000.
// RL20 - Clearing run enable freezes count; re-enabling resumes from held value.
// RL21 - Interrupt clear deasserts the output immediately, not on a count edge.
// RL22 - Prescale select field occupies control bits 3 down to 2.
// RL23 - Raw status sticky until cleared; output is raw status gated by enable.
//////////////////////////////////////////////////////////////////////////////
package ddt_pkg;

  localparam int unsigned CNT_W = 32;
  localparam int unsigned PRE_W = 8;
  localparam logic [31:0] LOAD_RST = 32'h0000_0000;
  localparam logic [31:0] VALUE_RST = 32'h0FFF_FFFF;
  localparam logic [31:0] MAX32 = 32'hFFFF_FFFF;
  localparam logic [15:0] MAX16 = 16'hFFFF;
  localparam logic [7:0] PRE_DIV16_TOP = 8'h0F;
  localparam logic [7:0] PRE_DIV256_TOP = 8'hFF;
  localparam int unsigned PRE_SEL_LSB = 2;
  localparam int unsigned PRE_SEL_MSB = 3;
  localparam logic [1:0] PRE_SEL_DIV1 = 2'h0;
  localparam logic [1:0] PRE_SEL_DIV16 = 2'h1;
  localparam logic [1:0] PRE_SEL_DIV256 = 2'h2;

  typedef enum logic [1:0] {
    DDT_MODE_FREE,
    DDT_MODE_PERIODIC,
    DDT_MODE_SINGLE_RUN_SELECT
  } ddt_mode_t;

  // Per-timer configuration, driven as plain ports
  typedef struct packed {
    logic counter_run_enable;
    logic counter_width_select;
    logic periodic_select;
    logic single_run_select;
    logic irq_mask_enable;
    logic [3:0] ctrl_bits;
  } ddt_cfg_t;

  // Per-timer software write strobes with data
  typedef struct packed {
    logic load_wr;
    logic bg_load_wr;
    logic irq_clr_wr;
    logic [31:0] wdata;
  } ddt_wr_t;

  // Per-timer status
  typedef struct packed {
    logic [31:0] value;
    logic [31:0] load;
    logic raw_irq;
    logic masked_irq;
  } ddt_stat_t;

endpackage

/* File: logic/ddt_dual_timer.sv */
// Dual down-counter timer with per-timer prescaler and interrupt
`timescale 1ns/1ps
`default_nettype none
module ddt_dual_timer #(
  parameter int unsigned NUM_TIMERS = 2,
  parameter logic [31:0] IDENT_CODE = 32'h0000_1234
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire logic clk_en_i,
  // Shared count clock qualifier and per-timer count enables
  input wire logic timer_count_clock_i,
  input wire logic count_enable_first_i,
  input wire logic count_enable_second_i,
  // Per-timer configuration and writes
  input wire ddt_pkg::ddt_cfg_t [NUM_TIMERS-1:0] cfg_i,
  input wire ddt_pkg::ddt_wr_t [NUM_TIMERS-1:0] wr_i,
  // Status, interrupts, identification
  output ddt_pkg::ddt_stat_t [NUM_TIMERS-1:0] stat_o,
  output logic [NUM_TIMERS-1:0] timer_irq_out_o,
  output logic [31:0] ident_o
);

  // Enable vector and status packing serve exactly two units
  if (NUM_TIMERS != 2) begin : g_bad_num_timers
    $error("NUM_TIMERS must be 2");
  end

  // Identification value, arbitrary
  assign ident_o = IDENT_CODE; // RL18

  logic [NUM_TIMERS-1:0] count_enable_per_timer;
  assign count_enable_per_timer = {count_enable_second_i, count_enable_first_i};

  //////////////////////////////////////////////////////////////////////////////
  genvar g;
  generate
    for (g = 0; g < NUM_TIMERS; g++) begin : g_unit
      logic [31:0] value_q, value_d;
      logic [31:0] load_q, load_d;
      logic [7:0] pre_q, pre_d;
      logic raw_q, raw_d;
      logic pend_q, pend_d;
      logic halted_q, halted_d;
      logic tick, pre_pulse, step, at_zero;
      logic [1:0] pre_sel;
      ddt_pkg::ddt_mode_t mode;

      always_comb begin
        pre_sel = cfg_i[g].ctrl_bits[ddt_pkg::PRE_SEL_MSB:ddt_pkg::PRE_SEL_LSB]; // RL22
        if (cfg_i[g].single_run_select) begin
          mode = ddt_pkg::DDT_MODE_SINGLE_RUN_SELECT;
        end else if (cfg_i[g].periodic_select) begin
          mode = ddt_pkg::DDT_MODE_FREE;
        end else begin
          mode = ddt_pkg::DDT_MODE_PERIODIC;
        end
        // Count edge: timer clock qualifier, per-timer count enable and run enable
        tick = timer_count_clock_i && count_enable_per_timer[g] && cfg_i[g].counter_run_enable; // RL2 RL15 RL20
        if (pre_sel == ddt_pkg::PRE_SEL_DIV16) begin
          pre_pulse = (pre_q[3:0] == 4'h0);
        end else if (pre_sel == ddt_pkg::PRE_SEL_DIV256) begin
          pre_pulse = (pre_q == 8'h00);
        end else begin
          pre_pulse = 1'b1;
        end
        step = tick && pre_pulse && !halted_q; // RL16
        if (cfg_i[g].counter_width_select) begin
          at_zero = (value_q == 32'h0000_0000);
        end else begin
          at_zero = (value_q[15:0] == 16'h0000); // RL19
        end
      end

      always_comb begin
        value_d = value_q;
        load_d = load_q;
        pre_d = pre_q;
        raw_d = raw_q;
        pend_d = pend_q;
        halted_d = halted_q;
        if (tick) begin
          if (pre_pulse) begin
            if (pre_sel == ddt_pkg::PRE_SEL_DIV16) begin
              pre_d = ddt_pkg::PRE_DIV16_TOP;
            end else begin
              pre_d = ddt_pkg::PRE_DIV256_TOP;
            end
          end else begin
            pre_d = pre_q - 8'h01; // RL15
          end
        end
        if (pend_q && tick) begin
          // Pending load applied on next enabled count edge
          value_d = load_q; // RL6 RL5
          pend_d = 1'b0;
          halted_d = 1'b0;
        end else if (step) begin
          if (at_zero) begin
            raw_d = 1'b1; // RL8 RL23
            if (mode == ddt_pkg::DDT_MODE_SINGLE_RUN_SELECT) begin
              halted_d = 1'b1; // RL5
            end else if (mode == ddt_pkg::DDT_MODE_PERIODIC) begin
              if (cfg_i[g].counter_width_select) begin
                value_d = load_q; // RL4 RL7
              end else begin
                value_d = {value_q[31:16], load_q[15:0]}; // RL4 RL19
              end
            end else if (cfg_i[g].counter_width_select) begin
              value_d = ddt_pkg::MAX32; // RL3
            end else begin
              value_d = {value_q[31:16], ddt_pkg::MAX16}; // RL3 RL19
            end
          end else if (cfg_i[g].counter_width_select) begin
            value_d = value_q - 32'h0000_0001; // RL1
          end else begin
            value_d = {value_q[31:16], value_q[15:0] - 16'h0001}; // RL19
          end
        end
        // Clear loses to a same-cycle zero event
        if (wr_i[g].irq_clr_wr && !(step && at_zero && !pend_q)) begin
          raw_d = 1'b0; // RL21 RL8
        end
        if (wr_i[g].load_wr) begin
          load_d = wr_i[g].wdata;
          pend_d = 1'b1; // RL6
        end else if (wr_i[g].bg_load_wr) begin
          load_d = wr_i[g].wdata; // RL7
        end
      end

      always_ff @(posedge ref_clk_i or negedge resetn_i) begin // RL11
        if (!resetn_i) begin
          value_q <= ddt_pkg::VALUE_RST; // RL14
          load_q <= ddt_pkg::LOAD_RST; // RL14
          pre_q <= 8'h00; // RL13
          raw_q <= 1'b0; // RL13
          pend_q <= 1'b0;
          halted_q <= 1'b0;
        end else if (clk_en_i) begin
          value_q <= value_d;
          load_q <= load_d;
          pre_q <= pre_d;
          raw_q <= raw_d;
          pend_q <= pend_d;
          halted_q <= halted_d;
        end
      end

      assign stat_o[g].value = value_q; // RL10
      assign stat_o[g].load = load_q;
      assign stat_o[g].raw_irq = raw_q;
      assign stat_o[g].masked_irq = raw_q && cfg_i[g].irq_mask_enable; // RL9 RL23
      assign timer_irq_out_o[g] = raw_q && cfg_i[g].irq_mask_enable; // RL9
    end
  endgenerate

endmodule
`default_nettype wire

/* File: test/ddt_tick_src.sv */
// Timer clock qualifier source facing the dual timer
`timescale 1ns/1ps
`default_nettype none
module ddt_tick_src (
  // Clock, mode and qualifier
  input wire logic clk_i,
  input wire logic half_i,
  output var logic tick_o
);
  initial tick_o = 1'b1;
  // Changes on the rising edge so the design sees the settled qualifier
  always @(posedge clk_i) tick_o <= half_i ? !tick_o : 1'b1;
endmodule
`default_nettype wire

/* File: test/ddt_dual_timer_monitor.sv */
// Assertion checker for the dual down-counter timer
`timescale 1ns/1ps
`default_nettype none
module ddt_dual_timer_monitor #(
  parameter int unsigned NUM_TIMERS = 2
) (
  // Design inputs
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire logic clk_en_i,
  input wire logic timer_count_clock_i,
  input wire logic count_enable_first_i,
  input wire ddt_pkg::ddt_cfg_t [NUM_TIMERS-1:0] cfg_i,
  input wire ddt_pkg::ddt_wr_t [NUM_TIMERS-1:0] wr_i,
  // Design outputs
  input wire ddt_pkg::ddt_stat_t [NUM_TIMERS-1:0] stat_o,
  input wire logic [NUM_TIMERS-1:0] timer_irq_out_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);
  logic pend_q;
  wire ddt_pkg::ddt_cfg_t c = cfg_i[0];
  wire ddt_pkg::ddt_wr_t w = wr_i[0];
  wire logic [31:0] v = stat_o[0].value;
  wire logic r = stat_o[0].raw_irq;
  wire logic e0 = clk_en_i & timer_count_clock_i & count_enable_first_i & c.counter_run_enable;
  wire logic ok = e0 & c.ctrl_bits[3:2] == 2'h0 & !pend_q & !w.load_wr;
  // Load written but not yet applied
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) pend_q <= 1'b0;
    else if (clk_en_i) pend_q <= w.load_wr | (pend_q & !e0);
  end
  sequence s_wrap;
    r && v == 32'hFFFF_FFFF;
  endsequence
  a_irq_gated: assert property (timer_irq_out_o[0] == (r & c.irq_mask_enable))
    else $error("irq not gated raw status");
  a_clear_drops: assert property (clk_en_i && w.irq_clr_wr && v[15:0] != 16'h0000 |=> !r)
    else $error("clear ignored");
  a_raw_sticky: assert property (r && !(clk_en_i && w.irq_clr_wr) |=> r)
    else $error("raw status lost");
  a_idle_hold: assert property (!e0 |=> $stable(v))
    else $error("value moved without count edge");
  a_load_taken: assert property (clk_en_i && (w.load_wr || w.bg_load_wr) |=> stat_o[0].load == $past(w.wdata))
    else $error("load not stored");
  a_upper_hold: assert property (!c.counter_width_select && !(pend_q && e0) |=> $stable(v[31:16]))
    else $error("upper half moved");
  a_count_step: assert property (ok && c.counter_width_select && v != 32'h0000_0000 |=> v == $past(v) - 1)
    else $error("bad decrement");
  a_free_wrap: assert property (ok && c.periodic_select && !c.single_run_select
    && c.counter_width_select && v == 32'h0000_0000 |=> s_wrap) else $error("no wrap at zero");
endmodule
bind ddt_dual_timer ddt_dual_timer_monitor #(.NUM_TIMERS(NUM_TIMERS)) mon_i (.ref_clk_i(ref_clk_i),
  .resetn_i(resetn_i), .clk_en_i(clk_en_i), .timer_count_clock_i(timer_count_clock_i),
  .count_enable_first_i(count_enable_first_i), .cfg_i(cfg_i), .wr_i(wr_i), .stat_o(stat_o),
  .timer_irq_out_o(timer_irq_out_o));
`default_nettype wire

/* File: test/ddt_dual_timer_tb.sv */
// Self-checking bench for the dual down-counter timer
`timescale 1ns/1ps
`default_nettype none
module ddt_dual_timer_tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic half = 1'b0;
  logic tick;
  ddt_pkg::ddt_cfg_t [1:0] cfg = {2{9'h010}};
  ddt_pkg::ddt_wr_t [1:0] wr = '0;
  ddt_pkg::ddt_stat_t [1:0] stat;
  logic [1:0] irq;
  logic [31:0] ident;
  logic en2 = 1'b0;
  // Identification value handed to the timer, arbitrary
  localparam logic [31:0] IDENT = 32'h0000_5A5A;
  int n_fail = 0;
  int tests_run = 0;
  always #2.5 clk = !clk;
  ddt_tick_src ddt_tick_src_i (.clk_i(clk), .half_i(half), .tick_o(tick));
  ddt_dual_timer #(.IDENT_CODE(IDENT)) ddt_dual_timer_i (.ref_clk_i(clk), .resetn_i(rst_n), .clk_en_i(1'b1),
    .timer_count_clock_i(tick), .count_enable_first_i(1'b1), .count_enable_second_i(en2),
    .cfg_i(cfg), .wr_i(wr), .stat_o(stat), .timer_irq_out_o(irq), .ident_o(ident));
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic ck(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic ckb(input logic g, input logic e);
    ck({31'h0000_0000, g}, {31'h0000_0000, e});
  endtask
  // Strobes: 4 load, 2 background load, 1 irq clear
  task automatic w(input logic [2:0] s, input logic [31:0] d);
    wr[0] = {s, d};
    cyc(1);
    wr[0] = '0;
  endtask
  task automatic complete_run;
    $display("tests_run=%0d n_fail=%0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    #5000;
    n_fail++;
    complete_run();
  end
  initial begin
    cyc(10);
    rst_n = 1'b1;
    cyc(1);
    ck(stat[0].value, 32'h0FFF_FFFF);
    ck(stat[1].value, 32'h0FFF_FFFF);
    ck(stat[0].load, 32'h0000_0000);
    ckb(irq[1], 1'b0);
    ckb(stat[0].raw_irq, 1'b0);
    ck(ident, IDENT);
    cfg[0] = 9'h1D0;
    w(3'h4, 32'h0000_0003);
    cyc(1);
    ck(stat[0].value, 32'h0000_0003);
    cyc(4);
    ck(stat[0].value, 32'hFFFF_FFFF);
    ckb(irq[0], 1'b1);
    ckb(stat[0].masked_irq, 1'b1);
    cfg[0] = 9'h1C0;
    cyc(1);
    ckb(irq[0], 1'b0);
    ckb(stat[0].masked_irq, 1'b0);
    ckb(stat[0].raw_irq, 1'b1);
    w(3'h1, 32'h0000_0000);
    ckb(stat[0].raw_irq, 1'b0);
    cfg[0] = 9'h190;
    cyc(1);
    w(3'h4, 32'h0000_0002);
    cyc(1);
    w(3'h2, 32'h0000_0005);
    ck(stat[0].load, 32'h0000_0005);
    ck(stat[0].value, 32'h0000_0001);
    cyc(2);
    ck(stat[0].value, 32'h0000_0005);
    ckb(irq[0], 1'b1);
    w(3'h1, 32'h0000_0000);
    cfg[0] = 9'h1B0;
    cyc(1);
    w(3'h4, 32'h0000_0001);
    cyc(5);
    ck(stat[0].value, 32'h0000_0000);
    ckb(stat[0].raw_irq, 1'b1);
    cfg[0] = 9'h1D0;
    w(3'h4, 32'h0000_0009);
    cyc(1);
    cfg[0] = 9'h0D0;
    cyc(4);
    ck(stat[0].value, 32'h0000_0009);
    half = 1'b1;
    cfg[0] = 9'h1D0;
    cyc(4);
    ck(stat[0].value, 32'h0000_0007);
    half = 1'b0;
    cfg[0] = 9'h0D0;
    cyc(1);
    cfg[0] = 9'h1D4;
    cyc(32);
    ck(stat[0].value, 32'h0000_0005);
    // 16-bit periodic: low half counts, upper half kept on reload
    cfg[0] = 9'h110;
    w(3'h5, 32'h0003_0002);
    cyc(1);
    ck(stat[0].value, 32'h0003_0002);
    ckb(stat[0].raw_irq, 1'b0);
    w(3'h2, 32'h0000_0004);
    cyc(1);
    ck(stat[0].value, 32'h0003_0000);
    ckb(irq[0], 1'b0);
    cyc(1);
    ck(stat[0].value, 32'h0003_0004);
    ckb(irq[0], 1'b1);
    // Divide by 256, then code 3 counts as divide by 1
    cfg[0] = 9'h118;
    cyc(255);
    ck(stat[0].value, 32'h0003_0004);
    cyc(1);
    ck(stat[0].value, 32'h0003_0003);
    cfg[0] = 9'h11C;
    cyc(2);
    ck(stat[0].value, 32'h0003_0001);
    // Second unit waits for its own count enable
    cfg[1] = 9'h1D0;
    cyc(3);
    ck(stat[1].value, 32'h0FFF_FFFF);
    en2 = 1'b1;
    cyc(2);
    ck(stat[1].value, 32'h0FFF_FFFD);
    ck(stat[0].value, 32'h0003_0001);
    complete_run();
  end
endmodule
`default_nettype wire
